/* csocp_top.sv */
// Purpose: over-current protection setup and one-time memory burn command
// Assumes: comparator outputs and gate levels synchronous to sys_clk
// Notes: read data valid only in the cycle after the read strobe
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "csocp_regs.svh"
// What this block does
// - The low nibble of the extension register picks the positive trip level, 20mV at the top code.
// - Bits 7:4 pick the negative trip level, from -300mV at code 0 shrinking to -20mV at code 15.
// - Bit 8 chooses whether a trip fault is held until cleared or follows the trip.
// - Bit 9 picks on-resistance sensing, which forces sampling to low-side-gate-on only.
// - Bit 10 makes a trip fault request braking and forces the fault to be held.
// - Bit 11 stops pulse truncation on a trip and so lets the trip filter delay fault raising.
// - Writing one to bit 0 of the burn register starts a memory burn; the bit is write-only.
// - Bits 4:1 of the burn register hold a readable, writable tag stored by the burn.
// - Bits 15:5 of the burn register read zero and ignore writes.
// - The trip filter is bypassed whenever truncation is enabled.
// - A fault is raised after 8 or 16 trip events, on every event, or never, by the trigger field.
module csocp_top
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire csocp_pkg::csocp_bus_req_t bus_req,
   output logic [15:0] reg_rdata,
   input wire logic [2:0] trip_pos_raw,
   input wire logic [2:0] trip_neg_raw,
   input wire logic [2:0] low_side_gate,
   input wire logic nvm_done,
   output logic [3:0] pos_trip_threshold,
   output logic [3:0] neg_trip_threshold,
   output logic [8:0] pos_trip_mv,
   output logic [8:0] neg_trip_mv,
   output logic [1:0] amp_timing_mode,
   output logic rdson_sense,
   output logic amp_reference_source,
   output logic pwm_cut,
   output logic trip_fault,
   output logic brake_req,
   output logic nvm_burn_start,
   output logic [3:0] user_version_tag,
   output logic nvm_busy,
   output logic irq
);
   import csocp_pkg::*;

   // ****************************************
   // threshold magnitude decode
   // ****************************************
   function automatic logic [8:0] thr_mag_mv(input logic [3:0] code);
      logic [8:0] mv;
      mv = 9'h014;
      case (code)
         4'h0: mv = 9'h12C;
         4'h1: mv = 9'h0FA;
         4'h2: mv = 9'h0E1;
         4'h3: mv = 9'h0C8;
         4'h4: mv = 9'h0AF;
         4'h5: mv = 9'h096;
         4'h6: mv = 9'h07D;
         4'h7: mv = 9'h064;
         4'h8: mv = 9'h05A;
         4'h9: mv = 9'h050;
         4'hA: mv = 9'h046;
         4'hB: mv = 9'h03C;
         4'hC: mv = 9'h032;
         4'hD: mv = 9'h028;
         4'hE: mv = 9'h01E;
         4'hF: mv = 9'h014;
         default: mv = 9'h014;
      endcase
      return mv;
   endfunction

   // ****************************************
   // registers
   // ****************************************
   csocp_ext_t ext_reg;
   csocp_ext_t ext_next;
   csocp_tcfg_t tcfg_reg;
   csocp_tcfg_t tcfg_next;
   logic [3:0] tag_reg;
   logic [3:0] tag_next;
   logic [`CSOCP_IRQ_W-1:0] istat_reg;
   logic [`CSOCP_IRQ_W-1:0] istat_next;
   logic [`CSOCP_IRQ_W-1:0] imask_reg;
   logic [`CSOCP_IRQ_W-1:0] imask_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [15:0] rd_mux;

   wire sel_ext = (bus_req.addr == `CSOCP_EXT_OFS);
   wire sel_burn = (bus_req.addr == `CSOCP_BURN_OFS);
   wire sel_tcfg = (bus_req.addr == `CSOCP_TCFG_OFS);
   wire sel_fstat = (bus_req.addr == `CSOCP_FSTAT_OFS);
   wire sel_istat = (bus_req.addr == `CSOCP_ISTAT_OFS);
   wire sel_imask = (bus_req.addr == `CSOCP_IMASK_OFS);
   wire wr_ext = bus_req.wr & sel_ext;
   wire wr_burn = bus_req.wr & sel_burn;
   wire wr_tcfg = bus_req.wr & sel_tcfg;
   wire wr_fstat = bus_req.wr & sel_fstat;
   wire wr_istat = bus_req.wr & sel_istat;
   wire wr_imask = bus_req.wr & sel_imask;

   // ****************************************
   // trip path
   // ****************************************
   logic trip_qual;
   logic trip_event;
   logic pwm_cut_reg;
   logic [1:0] tmode_reg;
   logic [8:0] pos_mv_reg;
   logic [8:0] neg_mv_reg;
   // on-resistance sensing is only valid while the low-side switch conducts
   wire [2:0] sample_win = ext_reg.rdson_sense ? low_side_gate : 3'h7;
   wire [2:0] phase_trip = (trip_pos_raw | trip_neg_raw) & sample_win;
   wire trip_level = |phase_trip;
   wire trunc_on = ~ext_reg.pulse_cut_disable;
   wire [1:0] tmode_next = ext_reg.rdson_sense ? `CSOCP_TMODE_LS_ON :
                           tcfg_reg.amp_timing_mode;

   csocp_trip_filter u_filter
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .trip_level(trip_level),
      .bypass(trunc_on),
      .trip_filter_time(tcfg_reg.trip_filter_time),
      .trip_qual(trip_qual),
      .trip_event(trip_event)
   );

   // ****************************************
   // event counting and fault
   // ****************************************
   logic [4:0] evt_cnt_reg;
   logic [4:0] evt_cnt_next;
   logic fault_reg;
   logic fault_next;
   csocp_trig_t trig;
   assign trig = csocp_trig_t'(tcfg_reg.trip_fault_trigger);
   wire [4:0] evt_limit = (trig == CSOCP_TRIG_CNT16) ? `CSOCP_TRIG_N16 : `CSOCP_TRIG_N8;
   wire cnt_hit = (evt_cnt_reg == (evt_limit - 5'h01));
   wire counting = (trig == CSOCP_TRIG_CNT8) | (trig == CSOCP_TRIG_CNT16);
   wire fault_raise = trip_event & ((trig == CSOCP_TRIG_EVERY) |
                                    (counting & cnt_hit));
   assign evt_cnt_next = (!counting) ? 5'h00 :
                         (!trip_event) ? evt_cnt_reg :
                         cnt_hit ? 5'h00 : (evt_cnt_reg + 5'h01);
   // brake forces hold, otherwise the brake would release mid-stop
   wire hold = ext_reg.trip_fault_hold | ext_reg.brake_on_trip;
   wire fault_clr = wr_fstat & bus_req.wdata[`CSOCP_FCLR_BIT];
   assign fault_next = fault_raise ? 1'b1 :
                       hold ? (fault_reg & ~fault_clr) :
                       (fault_reg & trip_qual);

   // ****************************************
   // memory burn command
   // ****************************************
   csocp_burn_t burn_reg;
   csocp_burn_t burn_next;
   logic start_reg;
   wire burn_req = wr_burn & bus_req.wdata[`CSOCP_BURN_START_BIT];
   wire burn_take = burn_req & (burn_reg == CSOCP_BURN_IDLE);
   wire burn_end = (burn_reg == CSOCP_BURN_BUSY) & nvm_done;
   always_comb
   begin
      burn_next = burn_reg;
      case (burn_reg)
         CSOCP_BURN_IDLE:
         begin
            if (burn_take)
               burn_next = CSOCP_BURN_BUSY;
         end
         CSOCP_BURN_BUSY:
         begin
            if (nvm_done)
               burn_next = CSOCP_BURN_IDLE;
         end
         default: burn_next = CSOCP_BURN_IDLE;
      endcase
   end
   // tag frozen during a burn so the stored word is the one started
   assign tag_next = (wr_burn && (burn_reg == CSOCP_BURN_IDLE)) ?
                     bus_req.wdata[`CSOCP_TAG_MSB:`CSOCP_TAG_LSB] : tag_reg;

   // ****************************************
   // write side
   // ****************************************
   wire [`CSOCP_IRQ_W-1:0] irq_set = {burn_end, fault_raise, trip_event};
   wire [`CSOCP_IRQ_W-1:0] irq_clr = wr_istat ? bus_req.wdata[`CSOCP_IRQ_W-1:0] :
                                    {`CSOCP_IRQ_W{1'b0}};
   assign ext_next = wr_ext ? csocp_ext_t'(bus_req.wdata & `CSOCP_EXT_MASK) : ext_reg;
   assign tcfg_next = wr_tcfg ? csocp_tcfg_t'(bus_req.wdata & `CSOCP_TCFG_MASK) : tcfg_reg;
   assign istat_next = (istat_reg & ~irq_clr) | irq_set;
   assign imask_next = wr_imask ? bus_req.wdata[`CSOCP_IRQ_W-1:0] : imask_reg;

   // ****************************************
   // read side
   // ****************************************
   wire [15:0] fstat_word = {8'h00, evt_cnt_reg, trip_qual,
                             (burn_reg == CSOCP_BURN_BUSY), fault_reg};
   wire [15:0] burn_word = {11'h000, tag_reg, 1'b0};
   assign rd_mux = sel_ext ? 16'(ext_reg) :
                   sel_burn ? burn_word :
                   sel_tcfg ? 16'(tcfg_reg) :
                   sel_fstat ? fstat_word :
                   sel_istat ? {13'h0000, istat_reg} :
                   sel_imask ? {13'h0000, imask_reg} : 16'h0000;
   assign rdata_next = bus_req.rd ? rd_mux : 16'h0000;

   // ****************************************
   // flip-flops
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_reg <= csocp_ext_t'(`CSOCP_EXT_RESET);
      end
      else
      begin
         ext_reg <= ext_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tcfg_reg <= csocp_tcfg_t'(`CSOCP_TCFG_RESET);
      end
      else
      begin
         tcfg_reg <= tcfg_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tag_reg <= 4'h0;
      end
      else
      begin
         tag_reg <= tag_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         istat_reg <= {`CSOCP_IRQ_W{1'b0}};
      end
      else
      begin
         istat_reg <= istat_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         imask_reg <= {`CSOCP_IRQ_W{1'b0}};
      end
      else
      begin
         imask_reg <= imask_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_reg <= 16'h0000;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_cnt_reg <= 5'h00;
         fault_reg <= 1'b0;
      end
      else
      begin
         evt_cnt_reg <= evt_cnt_next;
         fault_reg <= fault_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         burn_reg <= CSOCP_BURN_IDLE;
         start_reg <= 1'b0;
      end
      else
      begin
         burn_reg <= burn_next;
         start_reg <= burn_take;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwm_cut_reg <= 1'b0;
         tmode_reg <= 2'h0;
         pos_mv_reg <= 9'h000;
         neg_mv_reg <= 9'h000;
      end
      else
      begin
         // raw level keeps truncation fast; fault raising is separate
         pwm_cut_reg <= trip_level & trunc_on;
         tmode_reg <= tmode_next;
         pos_mv_reg <= thr_mag_mv(ext_reg.pos_trip_threshold);
         neg_mv_reg <= thr_mag_mv(ext_reg.neg_trip_threshold);
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = rdata_reg;
   assign pos_trip_threshold = ext_reg.pos_trip_threshold;
   assign neg_trip_threshold = ext_reg.neg_trip_threshold;
   assign pos_trip_mv = pos_mv_reg;
   assign neg_trip_mv = neg_mv_reg;
   assign amp_timing_mode = tmode_reg;
   assign rdson_sense = ext_reg.rdson_sense;
   // only the internal reference exists; bit passed on as stored
   assign amp_reference_source = ext_reg.amp_reference_source;
   assign pwm_cut = pwm_cut_reg;
   assign trip_fault = fault_reg;
   assign brake_req = fault_reg & ext_reg.brake_on_trip;
   assign nvm_burn_start = start_reg;
   assign user_version_tag = tag_reg;
   assign nvm_busy = (burn_reg == CSOCP_BURN_BUSY);
   assign irq = |(istat_reg & imask_reg);
endmodule

/* csocp_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock, 8-bit register address, 16-bit data
// Notes: included by bare name from csocp_top and csocp_trip_filter; the package does not include it
`ifndef CSOCP_REGS_SVH
`define CSOCP_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define CSOCP_EXT_OFS 8'h1E
`define CSOCP_BURN_OFS 8'h1F
`define CSOCP_TCFG_OFS 8'h20
`define CSOCP_FSTAT_OFS 8'h21
`define CSOCP_ISTAT_OFS 8'h22
`define CSOCP_IMASK_OFS 8'h23
// ****************************************
// reset values and field layout
// ****************************************
`define CSOCP_EXT_RESET 16'h0833
`define CSOCP_EXT_MASK 16'h1FFF
`define CSOCP_BURN_RESET 16'h0000
`define CSOCP_BURN_START_BIT 0
`define CSOCP_TAG_MSB 4
`define CSOCP_TAG_LSB 1
`define CSOCP_TCFG_RESET 16'h0000
`define CSOCP_TCFG_MASK 16'h003F
`define CSOCP_FCLR_BIT 0
`define CSOCP_IRQ_W 3
`define CSOCP_IRQ_TRIP 0
`define CSOCP_IRQ_FAULT 1
`define CSOCP_IRQ_BURN 2
`define CSOCP_TMODE_LS_ON 2'h1
`define CSOCP_TRIG_N8 5'h08
`define CSOCP_TRIG_N16 5'h10
// ****************************************
// timing
// ****************************************
`define CSOCP_CLK_MHZ 40
`define CSOCP_DGL_2US_NS 2000
`define CSOCP_DGL_4US_NS 4000
`define CSOCP_DGL_8US_NS 8000
`define CSOCP_NS2CYC(ns) ((((ns) * `CSOCP_CLK_MHZ) + 999) / 1000)
`define CSOCP_DGL_2US_CYC `CSOCP_NS2CYC(`CSOCP_DGL_2US_NS)
`define CSOCP_DGL_4US_CYC `CSOCP_NS2CYC(`CSOCP_DGL_4US_NS)
`define CSOCP_DGL_8US_CYC `CSOCP_NS2CYC(`CSOCP_DGL_8US_NS)
`endif

/* csocp_pkg.sv */
// Purpose: types shared by the protection register block
// Assumes: field layout as in csocp_regs.svh
// Notes: structs map one to one onto register words
package csocp_pkg;
   // ****************************************
   // register words
   // ****************************************
   typedef struct packed {
      logic [2:0] spare;
      logic amp_reference_source;
      logic pulse_cut_disable;
      logic brake_on_trip;
      logic rdson_sense;
      logic trip_fault_hold;
      logic [3:0] neg_trip_threshold;
      logic [3:0] pos_trip_threshold;
   } csocp_ext_t;
   typedef struct packed {
      logic [9:0] spare;
      logic [1:0] amp_timing_mode;
      logic [1:0] trip_fault_trigger;
      logic [1:0] trip_filter_time;
   } csocp_tcfg_t;
   // ****************************************
   // bus and modes
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } csocp_bus_req_t;
   typedef enum logic [1:0] {
      CSOCP_TRIG_CNT8 = 2'b00,
      CSOCP_TRIG_CNT16 = 2'b01,
      CSOCP_TRIG_EVERY = 2'b10,
      CSOCP_TRIG_NONE = 2'b11
   } csocp_trig_t;
   typedef enum logic {
      CSOCP_BURN_IDLE = 1'b0,
      CSOCP_BURN_BUSY = 1'b1
   } csocp_burn_t;
endpackage

/* csocp_trip_filter.sv */
// Purpose: deglitch of the combined trip level, with bypass
// Assumes: trip level already synchronous to sys_clk
// Notes: only the rising side is filtered; release is immediate
`timescale 1ns/10ps
`include "csocp_regs.svh"
module csocp_trip_filter
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic trip_level,
   input wire logic bypass,
   input wire logic [1:0] trip_filter_time,
   output logic trip_qual,
   output logic trip_event
);
   // ****************************************
   // filter
   // ****************************************
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic qual_reg;
   logic qual_next;
   logic evt_reg;
   logic [8:0] limit;
   wire no_filter = bypass | (trip_filter_time == 2'h0);
   wire at_limit = (cnt_reg >= (limit - 9'h001));
   assign limit = (trip_filter_time == 2'h1) ? 9'(`CSOCP_DGL_2US_CYC) :
                  (trip_filter_time == 2'h2) ? 9'(`CSOCP_DGL_4US_CYC) :
                  9'(`CSOCP_DGL_8US_CYC);
   // release must not wait, so a dropping level clears at once
   assign qual_next = trip_level & (no_filter | qual_reg | at_limit);
   assign cnt_next = (!trip_level || no_filter) ? 9'h000 :
                     at_limit ? cnt_reg : (cnt_reg + 9'h001);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 9'h000;
         qual_reg <= 1'b0;
         evt_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         qual_reg <= qual_next;
         evt_reg <= qual_next & ~qual_reg;
      end
   end
   assign trip_qual = qual_reg;
   assign trip_event = evt_reg;
endmodule

/* csocp_top_asserts.sv */
// Purpose: concurrent checks on the csocp_top ports
// Assumes: one clock domain, reset active low
// Notes: bound to every csocp_top instance
`timescale 1ns/10ps
module csocp_top_asserts
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire csocp_pkg::csocp_bus_req_t bus_req,
   input wire logic [15:0] reg_rdata,
   input wire logic [2:0] trip_pos_raw,
   input wire logic [2:0] trip_neg_raw,
   input wire logic [3:0] pos_trip_threshold,
   input wire logic [3:0] neg_trip_threshold,
   input wire logic [1:0] amp_timing_mode,
   input wire logic rdson_sense,
   input wire logic pwm_cut,
   input wire logic trip_fault,
   input wire logic brake_req,
   input wire logic nvm_burn_start,
   input wire logic [3:0] user_version_tag,
   input wire logic nvm_busy
);
   import csocp_pkg::*;
   wire ext_w = bus_req.wr && bus_req.addr == 8'h1E;
   wire burn_w = bus_req.wr && bus_req.addr == 8'h1F;
   wire fclr_w = bus_req.wr && bus_req.addr == 8'h21 && bus_req.wdata[0];
   wire any_trip = |{trip_pos_raw, trip_neg_raw};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ********
   // burn start steps
   // ********
   sequence s_go;
      burn_w && bus_req.wdata[0] && !nvm_busy;
   endsequence
   sequence s_pulse;
      nvm_burn_start && nvm_busy ##1 !nvm_burn_start;
   endsequence
   property p_pos;
      ext_w |=> pos_trip_threshold == $past(bus_req.wdata[3:0]);
   endproperty
   a_pos: assert property (p_pos) else $error("pos code not taken");
   property p_neg;
      ext_w |=> neg_trip_threshold == $past(bus_req.wdata[7:4]);
   endproperty
   a_neg: assert property (p_neg) else $error("neg code not taken");
   property p_tmode;
      rdson_sense |=> amp_timing_mode == 2'h1;
   endproperty
   a_tmode: assert property (p_tmode) else $error("timing mode not forced");
   // an ext write may drop the hold, so it is left out
   property p_brake;
      brake_req && !fclr_w && !ext_w |-> trip_fault ##1 trip_fault;
   endproperty
   a_brake: assert property (p_brake) else $error("brake fault not held");
   property p_cut;
      pwm_cut |-> $past(any_trip);
   endproperty
   a_cut: assert property (p_cut) else $error("cut without trip");
   property p_burn;
      s_go |=> s_pulse;
   endproperty
   a_burn: assert property (p_burn) else $error("burn start not one pulse");
   property p_tag;
      burn_w |=> user_version_tag == ($past(nvm_busy) ? $past(user_version_tag)
         : $past(bus_req.wdata[4:1]));
   endproperty
   a_tag: assert property (p_tag) else $error("tag update wrong");
   property p_zero;
      bus_req.rd && bus_req.addr == 8'h1F |=> reg_rdata[15:5] == 11'h000 && !reg_rdata[0];
   endproperty
   a_zero: assert property (p_zero) else $error("burn read not zero");
endmodule
bind csocp_top csocp_top_asserts u_csocp_top_asserts
(
   .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
   .trip_pos_raw(trip_pos_raw), .trip_neg_raw(trip_neg_raw),
   .pos_trip_threshold(pos_trip_threshold), .neg_trip_threshold(neg_trip_threshold),
   .amp_timing_mode(amp_timing_mode), .rdson_sense(rdson_sense), .pwm_cut(pwm_cut),
   .trip_fault(trip_fault), .brake_req(brake_req), .nvm_burn_start(nvm_burn_start),
   .user_version_tag(user_version_tag), .nvm_busy(nvm_busy)
);

/* csocp_top_tb.sv */
// Purpose: self-checking bench for csocp_top
// Assumes: 40 MHz sys_clk, status and config map as handed over
// Notes: read data is checked from a queue by a watcher
`timescale 1ns/10ps
module csocp_top_tb;
   import csocp_pkg::*;
   logic sys_clk;
   logic rst_n;
   csocp_bus_req_t bus_req;
   logic [15:0] reg_rdata;
   logic [2:0] trip_pos_raw;
   logic [2:0] trip_neg_raw;
   logic [2:0] low_side_gate;
   logic nvm_done;
   logic [3:0] pos_thr;
   logic [3:0] neg_thr;
   logic [8:0] pos_trip_mv;
   logic [8:0] neg_trip_mv;
   logic [1:0] amp_timing_mode;
   logic rdson_sense;
   logic pwm_cut;
   logic trip_fault;
   logic brake_req;
   logic [3:0] user_version_tag;
   logic nvm_busy;
   logic nvm_burn_start;
   logic amp_reference_source;
   logic irq;
   logic rd_d;
   logic [15:0] d;
   logic [15:0] exp_q[$];
   int error_cnt;
   int compares;
   int cyc_cnt;
   int mv_tab[16] = '{300, 250, 225, 200, 175, 150, 125, 100, 90, 80, 70, 60, 50, 40, 30, 20};
   csocp_top u_csocp_top
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
      .trip_pos_raw(trip_pos_raw), .trip_neg_raw(trip_neg_raw), .nvm_done(nvm_done),
      .low_side_gate(low_side_gate), .pos_trip_threshold(pos_thr),
      .neg_trip_threshold(neg_thr), .pos_trip_mv(pos_trip_mv), .neg_trip_mv(neg_trip_mv),
      .amp_timing_mode(amp_timing_mode), .rdson_sense(rdson_sense),
      .amp_reference_source(amp_reference_source), .pwm_cut(pwm_cut),
      .trip_fault(trip_fault), .brake_req(brake_req),
      .nvm_burn_start(nvm_burn_start), .user_version_tag(user_version_tag),
      .nvm_busy(nvm_busy), .irq(irq)
   );
   // ********
   // tasks
   // ********
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chb(input string nm, input logic e, input logic g);
      chk(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   // outputs are sampled 1 ns after the edge, once its updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
   endtask
   task automatic pulse(input logic [2:0] p, input logic [2:0] n);
      @(posedge sys_clk);
      trip_pos_raw <= p;
      trip_neg_raw <= n;
      cyc(3);
   endtask
   // ********
   // clock, watcher, sequence
   // ********
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      rd_d <= bus_req.rd;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   always @(negedge sys_clk)
   begin
      if (rd_d === 1'b1)
         chk("reg_rdata", exp_q.pop_front(), reg_rdata);
   end
   initial
   begin
      void'($urandom(32'h48F09172));
      bus_req = '0;
      trip_pos_raw = 3'h0;
      trip_neg_raw = 3'h0;
      low_side_gate = 3'h7;
      nvm_done = 1'b0;
      rst_n = 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus_rd(8'h1E, 16'h0833);
      bus_rd(8'h1F, 16'h0000);
      bus_wr(8'h40, 16'hFFFF);
      bus_rd(8'h40, 16'h0000);
      chk("pos_mv", 16'h00C8, {7'h00, pos_trip_mv});
      $display("test reset done");
      bus_wr(8'h20, 16'h0030);
      for (int i = 0; i < 16; i++)
      begin
         d = 16'($urandom) & 16'hEF00 | 16'(i) | 16'(15 - i) << 4;
         bus_wr(8'h1E, d);
         bus_rd(8'h1E, d & 16'h1FFF);
         chk("pos_mv", 16'(mv_tab[i]), {7'h00, pos_trip_mv});
         chk("neg_mv", 16'(mv_tab[15 - i]), {7'h00, neg_trip_mv});
         chk("tmode", d[9] ? 16'h0001 : 16'h0003, {14'h0000, amp_timing_mode});
         chk("pos_thr", 16'(i), {12'h000, pos_thr});
         chk("neg_thr", 16'(15 - i), {12'h000, neg_thr});
         chb("rdson", d[9], rdson_sense);
         chb("ref_src", 1'b0, amp_reference_source);
      end
      $display("test extension done");
      bus_wr(8'h1F, 16'hFFF3);
      chb("busy", 1'b1, nvm_busy);
      chb("start", 1'b1, nvm_burn_start);
      chk("tag", 16'h0009, {12'h000, user_version_tag});
      bus_rd(8'h1F, 16'h0012);
      bus_wr(8'h1F, 16'h0005);
      chb("start", 1'b0, nvm_burn_start);
      chk("tag", 16'h0009, {12'h000, user_version_tag});
      @(posedge sys_clk);
      nvm_done <= 1'b1;
      @(posedge sys_clk);
      nvm_done <= 1'b0;
      bus_rd(8'h22, 16'h0004);
      chb("busy", 1'b0, nvm_busy);
      bus_wr(8'h22, 16'h0004);
      bus_rd(8'h22, 16'h0000);
      $display("test burn done");
      bus_wr(8'h20, 16'h0008);
      bus_wr(8'h1E, 16'h0033);
      bus_wr(8'h23, 16'h0002);
      pulse(3'($urandom_range(7, 1)), 3'h0);
      chb("cut", 1'b1, pwm_cut);
      chb("fault", 1'b1, trip_fault);
      chb("irq", 1'b1, irq);
      pulse(3'h0, 3'h0);
      chb("fault", 1'b0, trip_fault);
      chb("irq", 1'b1, irq);
      bus_wr(8'h22, 16'h0007);
      chb("irq", 1'b0, irq);
      bus_wr(8'h1E, 16'h0833);
      pulse(3'h0, 3'h4);
      chb("cut", 1'b0, pwm_cut);
      chb("fault", 1'b1, trip_fault);
      pulse(3'h0, 3'h0);
      bus_wr(8'h1E, 16'h0433);
      pulse(3'h2, 3'h0);
      pulse(3'h0, 3'h0);
      chb("brake", 1'b1, brake_req);
      chb("fault", 1'b1, trip_fault);
      bus_wr(8'h21, 16'h0001);
      chb("fault", 1'b0, trip_fault);
      $display("test trip done");
      bus_wr(8'h20, 16'h000C);
      bus_wr(8'h1E, 16'h0933);
      pulse(3'h1, 3'h0);
      pulse(3'h0, 3'h0);
      chb("fault", 1'b0, trip_fault);
      for (int m = 0; m < 2; m++)
      begin
         bus_wr(8'h20, 16'(m) << 2);
         for (int k = 0; k < (8 << m); k++)
         begin
            chb("fault", 1'b0, trip_fault);
            pulse(3'h1, 3'h0);
            pulse(3'h0, 3'h0);
         end
         chb("fault", 1'b1, trip_fault);
         bus_wr(8'h21, 16'h0001);
      end
      bus_wr(8'h20, 16'h0009);
      pulse(3'h1, 3'h0);
      pulse(3'h0, 3'h0);
      chb("fault", 1'b0, trip_fault);
      pulse(3'h1, 3'h0);
      cyc(85);
      chb("fault", 1'b1, trip_fault);
      pulse(3'h0, 3'h0);
      bus_wr(8'h21, 16'h0001);
      chb("fault", 1'b0, trip_fault);
      bus_wr(8'h1E, 16'h0133);
      pulse(3'h1, 3'h0);
      pulse(3'h0, 3'h0);
      chb("fault", 1'b1, trip_fault);
      $display("test trigger done");
      cyc(2);
      finish_test();
   end
endmodule
